// *** core/ntr_pkg.sv ***
package ntr_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BANK = 8'h08;
  localparam logic [7:0] ADDR_TPTR = 8'h0C;
  localparam logic [7:0] ADDR_TLAT = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_IDXBASE = 8'h18;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // Instruction encodings
  localparam logic [6:0] OPC_NEGATE = 7'h36;
  localparam logic [13:0] OPC_TABLE_READ = 14'h0002;
  localparam int ACC_BIT = 8;
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [1:0] TBL_NOCHG = 2'h0;
  localparam logic [1:0] TBL_POSTINC = 2'h1;
  localparam logic [1:0] TBL_POSTDEC = 2'h2;
  localparam logic [1:0] TBL_PREINC = 2'h3;

  // ==========================================================================
  // Field positions in STATUS and CTRL
  localparam int ST_C = 0;
  localparam int ST_DCF = 1;
  localparam int ST_Z = 2;
  localparam int ST_OVF = 3;
  localparam int ST_N = 4;
  localparam int ST_BUSY = 8;
  localparam int ST_ILLEGAL = 9;
  localparam int CTRL_EXT = 0;

  // ==========================================================================
  // Widths and reset values
  localparam int TPTR_W = 21;
  localparam int DADDR_W = 12;
  localparam logic [TPTR_W-1:0] TPTR_RST = 21'h000000;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [DADDR_W-1:0] IDXBASE_RST = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC = 3'b001,
    ST_NRD = 3'b010,
    ST_NWR = 3'b011,
    ST_TRD = 3'b100,
    ST_TWT = 3'b101,
    ST_TLAT = 3'b110
  } ntr_state_e;

endpackage

// *** core/ntr_exec.sv ***
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
// Function
// RULE_01 - Negate replaces the data byte with inverted value plus one, updating five flags.
// RULE_02 - Negate decodes from seven fixed opcode bits, access bit, eight address bits.
// RULE_03 - Access bit zero resolves the address inside the fixed access bank.
// RULE_04 - Access bit one takes the bank number from the bank select register.
// RULE_05 - Access zero, extended set on, address at most 95: indexed literal offset.
// RULE_06 - Table read fetches one program byte at the pointer into the table latch.
// RULE_07 - Table read pointer modes: unchanged, post-increment, post-decrement, pre-increment.
// RULE_08 - The table pointer is 21 bits, a bytewise 2-Mbyte range.
// RULE_09 - Pointer bit 0 picks the low byte when zero, high byte when one.
// RULE_10 - Table read takes two instruction cycles: decode, then read and latch write. Here four clocks: ST_DEC, ST_TRD, ST_TWT, ST_TLAT.
// RULE_11 - No-operation takes one cycle and changes no register, flag or memory.
module ntr_exec
  import ntr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DADDR_W-1:0] dmem_addr,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  output logic [TPTR_W-2:0] pmem_addr,
  input wire logic [15:0] pmem_rdata
);

  // ==========================================================================
  // State
  ntr_state_e state_r;
  logic [15:0] instr_r;
  logic [4:0] flags_r;
  logic illegal_r, ext_en_r, aw_full_r, w_full_r, wr_go, busy, is_negate, is_table_read;
  logic [3:0] bank_select_register_r, w_strb_r;
  logic [TPTR_W-1:0] table_pointer_r;
  logic [7:0] table_latch_r, aw_addr_r, f_addr, neg_res;
  logic [DADDR_W-1:0] idx_base_r, eff_addr;
  logic [31:0] w_data_r, wr_val;

  assign busy = (state_r != ST_IDLE);
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign f_addr = instr_r[7:0];
  assign is_negate = (instr_r[15:9] == OPC_NEGATE); // RULE_02
  assign is_table_read = (instr_r[15:2] == OPC_TABLE_READ);
  assign neg_res = 8'(~dmem_rdata + 8'h01); // RULE_01

  // Byte-lane merge of the write data over the current register value
  always_comb
  begin
    wr_val = 32'h00000000;
    unique case (aw_addr_r)
      ADDR_BANK: wr_val = {28'h0000000, bank_select_register_r};
      ADDR_TPTR: wr_val = {11'h000, table_pointer_r};
      ADDR_CTRL: wr_val = {31'h00000000, ext_en_r};
      ADDR_IDXBASE: wr_val = {20'h00000, idx_base_r};
      default: wr_val = {16'h0000, instr_r};
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (w_strb_r[i])
      begin
        wr_val[i*8 +: 8] = w_data_r[i*8 +: 8];
      end
    end
  end

  // Effective data address; access bank splits at the literal offset limit
  assign eff_addr = instr_r[ACC_BIT] ? {bank_select_register_r, f_addr} // RULE_04
    : (ext_en_r && f_addr <= LIT_OFFSET_MAX) ? 12'(idx_base_r + {4'h0, f_addr}) // RULE_05
    : (f_addr <= LIT_OFFSET_MAX) ? {4'h0, f_addr} // RULE_03
    : {ACCESS_HIGH_BANK, f_addr}; // RULE_03

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_r)
          ADDR_INSTR, ADDR_TPTR, ADDR_BANK: s_axi_bresp <= busy ? RESP_SLVERR : RESP_OKAY;
          ADDR_CTRL, ADDR_IDXBASE: s_axi_bresp <= RESP_OKAY;
          ADDR_STATUS, ADDR_TLAT: s_axi_bresp <= RESP_SLVERR;
          default: s_axi_bresp <= RESP_DECERR;
        endcase
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel, one-cycle answer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case ({s_axi_araddr[7:2], 2'h0})
          ADDR_INSTR: s_axi_rdata <= {16'h0000, instr_r};
          ADDR_STATUS: s_axi_rdata <= {22'h000000, illegal_r, busy, 3'h0, flags_r};
          ADDR_BANK: s_axi_rdata <= {28'h0000000, bank_select_register_r};
          ADDR_TPTR: s_axi_rdata <= {11'h000, table_pointer_r};
          ADDR_TLAT: s_axi_rdata <= {24'h000000, table_latch_r};
          ADDR_CTRL: s_axi_rdata <= {31'h00000000, ext_en_r};
          ADDR_IDXBASE: s_axi_rdata <= {20'h00000, idx_base_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration registers; writes to bank select are refused while busy
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bank_select_register_r <= BANK_RST;
      ext_en_r <= 1'b0;
      idx_base_r <= IDXBASE_RST;
    end
    else if (wr_go)
    begin
      if (aw_addr_r == ADDR_BANK && !busy) bank_select_register_r <= wr_val[3:0];
      if (aw_addr_r == ADDR_CTRL) ext_en_r <= wr_val[CTRL_EXT];
      if (aw_addr_r == ADDR_IDXBASE) idx_base_r <= wr_val[DADDR_W-1:0];
    end
  end

  // ==========================================================================
  // Instruction sequencer; a write to INSTR while idle issues it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_IDLE;
      instr_r <= 16'h0000;
      illegal_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (wr_go && aw_addr_r == ADDR_INSTR)
          begin
            instr_r <= wr_val[15:0];
            state_r <= ST_DEC;
          end
        ST_DEC:
        begin
          // Anything not decoded here ends like a no-operation
          illegal_r <= !(is_negate || is_table_read || instr_r == 16'h0000
                         || instr_r[15:12] == 4'hF);
          state_r <= is_negate ? ST_NRD : (is_table_read ? ST_TRD : ST_IDLE); // RULE_11
        end
        ST_NRD: state_r <= ST_NWR;
        ST_NWR: state_r <= ST_IDLE;
        ST_TRD: state_r <= ST_TWT; // RULE_10
        ST_TWT: state_r <= ST_TLAT;
        ST_TLAT: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Data memory port: read the operand, then write its negation back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dmem_addr <= 12'h000;
      dmem_we <= 1'b0;
      dmem_wdata <= 8'h00;
      flags_r <= 5'h00;
    end
    else
    begin
      dmem_we <= 1'b0;
      if (state_r == ST_DEC && is_negate)
      begin
        dmem_addr <= eff_addr;
      end
      if (state_r == ST_NWR)
      begin
        dmem_we <= 1'b1; // RULE_01
        dmem_wdata <= neg_res;
        flags_r[ST_N] <= neg_res[7];
        flags_r[ST_OVF] <= (dmem_rdata == 8'h80);
        flags_r[ST_C] <= (dmem_rdata == 8'h00);
        flags_r[ST_DCF] <= (dmem_rdata[3:0] == 4'h0);
        flags_r[ST_Z] <= (neg_res == 8'h00);
      end
    end
  end

  // ==========================================================================
  // Table pointer, program memory port and table latch
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      table_pointer_r <= TPTR_RST;
      table_latch_r <= 8'h00;
      pmem_addr <= 20'h00000;
    end
    else
    begin
      if (wr_go && aw_addr_r == ADDR_TPTR && !busy)
        table_pointer_r <= wr_val[TPTR_W-1:0]; // RULE_08
      if (state_r == ST_DEC && is_table_read && instr_r[1:0] == TBL_PREINC)
        table_pointer_r <= 21'(table_pointer_r + 21'h000001); // RULE_07
      if (state_r == ST_TRD) pmem_addr <= table_pointer_r[TPTR_W-1:1]; // RULE_06
      if (state_r == ST_TLAT)
      begin
        table_latch_r <= table_pointer_r[0] ? pmem_rdata[15:8] : pmem_rdata[7:0]; // RULE_09
        unique case (instr_r[1:0])
          TBL_POSTINC: table_pointer_r <= 21'(table_pointer_r + 21'h000001); // RULE_07
          TBL_POSTDEC: table_pointer_r <= 21'(table_pointer_r - 21'h000001); // RULE_07
          TBL_NOCHG, TBL_PREINC: table_pointer_r <= table_pointer_r;
        endcase
      end
    end
  end

endmodule

// *** tb/ntr_mem_model.sv ***
`timescale 1ns/100ps
module ntr_mem_model
  import ntr_pkg::*;
(
  input wire logic clk,
  input wire logic [DADDR_W-1:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  input wire logic [TPTR_W-2:0] pmem_addr,
  output logic [15:0] pmem_rdata
);
  // Seed bytes: 000h holds 00h and 080h holds 80h
  function automatic logic [7:0] dv(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  // Program words follow bits 15:0 of the word address; bytes repeat every 64K words
  function automatic logic [15:0] pw(input logic [19:0] a);
    return {a[7:0] ^ 8'h5A, a[15:8] + a[7:0]};
  endfunction
  logic [7:0] mem [0:4095];
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = dv(12'(i));
  end
  // Both arrays answer one cycle after the address, like real RAM
  always @(posedge clk)
  begin
    if (dmem_we) mem[dmem_addr] <= dmem_wdata;
    dmem_rdata <= mem[dmem_addr];
    pmem_rdata <= pw(pmem_addr);
  end
endmodule

// *** tb/ntr_exec_monitor.sv ***
`timescale 1ns/100ps
module ntr_exec_monitor
  import ntr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [DADDR_W-1:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  input wire logic [TPTR_W-2:0] pmem_addr
);
  // ==========================================================================
  // Shadow state; a write counts only once its OKAY answer shows
  logic [7:0] wa;
  logic [31:0] wd;
  logic bq;
  logic ext;
  logic [3:0] bk;
  logic [11:0] ib;
  logic [20:0] tp;
  logic [19:0] tv;
  wire go = s_axi_bvalid && !bq && s_axi_bresp == RESP_OKAY;
  wire ig = go && wa == ADDR_INSTR;
  wire ng = ig && wd[15:9] == OPC_NEGATE;
  wire tg = ig && wd[15:2] == OPC_TABLE_READ;
  wire lit = !wd[ACC_BIT] && wd[7:0] <= LIT_OFFSET_MAX;
  wire [20:0] fp = wd[1:0] == TBL_PREINC ? tp + 21'h1 : tp;
  always_ff @(posedge clk)
  begin
    bq <= s_axi_bvalid;
    // Word address the accepted table read must present
    if (tg) tv <= fp[20:1];
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
  end
  // Pointer follows each accepted table read
  always_ff @(posedge clk)
  begin
    if (srst) {ext, bk, ib, tp} <= '0;
    else if (go && wa == ADDR_BANK) bk <= wd[3:0];
    else if (go && wa == ADDR_CTRL) ext <= wd[CTRL_EXT];
    else if (go && wa == ADDR_IDXBASE) ib <= wd[11:0];
    else if (go && wa == ADDR_TPTR) tp <= wd[20:0];
    else if (tg && wd[1:0] == TBL_POSTDEC) tp <= tp - 21'h1;
    else if (tg && wd[1:0] != TBL_NOCHG) tp <= tp + 21'h1;
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_neg_val;
    dmem_we |-> dmem_wdata == 8'(~dmem_rdata + 8'h01);
  endproperty
  a_neg_val: assert property (p_neg_val)
    else $error("negate result wrong");
  property p_we_pulse;
    dmem_we |=> !dmem_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse too long");
  property p_bank;
    ng && wd[ACC_BIT] |-> ##[1:4] dmem_we && dmem_addr == {bk, wd[7:0]};
  endproperty
  a_bank: assert property (p_bank)
    else $error("banked address wrong");
  property p_acc;
    ng && !wd[ACC_BIT] && !(lit && ext) |-> ##[1:4] dmem_we
      && dmem_addr == {lit ? 4'h0 : ACCESS_HIGH_BANK, wd[7:0]};
  endproperty
  a_acc: assert property (p_acc)
    else $error("access bank address wrong");
  property p_idx;
    ng && lit && ext |-> ##[1:4] dmem_we && dmem_addr == 12'(ib + wd[7:0]);
  endproperty
  a_idx: assert property (p_idx)
    else $error("indexed address wrong");
  property p_nowr;
    ig && wd[15:9] != OPC_NEGATE |=> !dmem_we [*4];
  endproperty
  a_nowr: assert property (p_nowr)
    else $error("data write without negate");
  property p_nop;
    ig && wd[15:0] == 16'h0000 |=> ($stable(dmem_addr) && $stable(pmem_addr)) [*4];
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op moved an address");
  property p_tbl;
    tg |=> $stable(pmem_addr) ##1 pmem_addr == tv;
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("program address wrong");
endmodule
bind ntr_exec ntr_exec_monitor u_mon (.*);

// *** tb/ntr_exec_tb_top.sv ***
`timescale 1ns/100ps
module ntr_exec_tb_top
  import ntr_pkg::*;
;
  logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, dmem_we, ext;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dmem_wdata, dmem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb, bk;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [11:0] dmem_addr, ib;
  logic [19:0] pmem_addr;
  logic [15:0] pmem_rdata;
  logic [20:0] tp;
  logic [7:0] dm [logic [11:0]];
  logic [4:0] w_save;
  int err_count, compares;
  ntr_exec u_dut (.*);
  ntr_mem_model u_mem (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record every data write so repeated addresses stay predictable
  always @(posedge clk)
    if (dmem_we === 1'b1) dm[dmem_addr] = dmem_wdata;
  task stop_test(input int e);
    err_count += e;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, s, e);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (n >= 50) stop_test(1);
  endtask
  task rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    {r, rs} = {s_axi_rdata, s_axi_rresp};
    if (n >= 50) stop_test(1);
  endtask
  task ins(input logic [15:0] d);
    int n;
    wr(ADDR_INSTR, {16'h0000, d});
    chk(rs, RESP_OKAY);
    // Force at least one status poll so a stale idle reading never ends the wait
    r = '1;
    for (n = 0; n < 20 && r[ST_BUSY] !== 1'b0; n++)
      rd(ADDR_STATUS);
    if (r[ST_BUSY] !== 1'b0) stop_test(1);
  endtask
  task neg(input logic a, input logic [7:0] f);
    logic [11:0] ea;
    logic [7:0] v, x;
    ea = a ? {bk, f} : (f > LIT_OFFSET_MAX ? {ACCESS_HIGH_BANK, f} : (ext ? ib + f : f));
    v = dm.exists(ea) ? dm[ea] : u_mem.dv(ea);
    x = ~v + 8'h01;
    r = '1;
    ins({OPC_NEGATE, a, f});
    chk(dm[ea], x);
    rd(ADDR_STATUS);
    chk(r[4:0], {x[7], v == 8'h80, x == 8'h00, v[3:0] == 4'h0, v == 8'h00});
  endtask
  task tbl(input logic [1:0] md);
    logic [20:0] p;
    logic [15:0] w;
    p = md == TBL_PREINC ? tp + 21'h1 : tp;
    w = u_mem.pw(p[20:1]);
    r = '1;
    ins({OPC_TABLE_READ, md});
    rd(ADDR_TLAT);
    chk(r, p[0] ? w[15:8] : w[7:0]);
    tp = md == TBL_POSTDEC ? tp - 21'h1 : (md == TBL_NOCHG ? tp : tp + 21'h1);
    rd(ADDR_TPTR);
    chk(r, tp);
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {48'h0, 4'hF};
    {err_count, compares, bk, ext, ib, tp} = '0;
    void'($urandom(32'hEC32D0A0));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4));
      chk(r, 32'h0);
      chk(rs, i == 7 ? RESP_DECERR : RESP_OKAY);
    end
    wr(ADDR_TLAT, 32'hFF);
    chk(rs, RESP_SLVERR);
    neg(1'b1, 8'h00);
    neg(1'b1, 8'h80);
    neg(1'b0, 8'hA0);
    neg(1'b0, 8'h5F);
    {ext, ib} = {1'b1, 12'hFF0};
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_IDXBASE, {20'h0, ib});
    neg(1'b0, 8'h5F);
    neg(1'b0, 8'h60);
    repeat (6)
    begin
      bk = 4'($urandom);
      wr(ADDR_BANK, {28'h0, bk});
      neg(1'b1, 8'($urandom));
    end
    rd(ADDR_STATUS);
    s_axi_wstrb <= 4'hF;
    {w_save} = r[4:0];
    ins(16'h0000);
    ins(16'hF5A3);
    rd(ADDR_STATUS);
    chk(r[4:0], w_save);
    tp = 21'h1FFFFF;
    wr(ADDR_TPTR, {11'h0, tp});
    for (int m = 0; m < 8; m++)
    begin
      if (m == 4) tp = 21'($urandom);
      if (m == 4) wr(ADDR_TPTR, {11'h0, tp});
      tbl(2'(m ^ 1));
    end
    stop_test(0);
  end
  initial
  begin
    #900000;
    stop_test(1);
  end
endmodule
